// >>> src/csr_pkg.sv
/*
  Package for the charger state and fault status register: command code,
  bit positions, reset value, carrier structs.
  Assumes a surrounding SMBus slave that decodes transactions into
  single-cycle read and write strobes with a command code and a 16-bit word.
*/
package csr_pkg;

  localparam logic [7:0] CSR_CMD_STATUS = 8'h20;
  localparam logic [15:0] CSR_STATUS_RESET = 16'h0000;
  localparam int CSR_REG_WIDTH = 16;

  // Bit positions
  localparam int CSR_BIT_INPUT_PRESENT = 15;
  localparam int CSR_BIT_OPT_COMPLETE = 14;
  localparam int CSR_BIT_SUPPLEMENT = 13;
  localparam int CSR_BIT_VOLT_REG = 12;
  localparam int CSR_BIT_CURR_REG = 11;
  localparam int CSR_BIT_FAST_CHARGE = 10;
  localparam int CSR_BIT_PRECHARGE = 9;
  localparam int CSR_BIT_BUS_SUPPLY = 8;
  localparam int CSR_BIT_IN_OV = 7;
  localparam int CSR_BIT_BAT_OC = 6;
  localparam int CSR_BIT_IN_OC = 5;
  localparam int CSR_BIT_SYS_OV = 4;
  localparam int CSR_BIT_SYSTEM_SHORT_FAULT = 3;
  localparam int CSR_BIT_LATCHOFF = 2;
  localparam int CSR_BIT_BUS_OV = 1;
  localparam int CSR_BIT_BUS_UV = 0;

  // Read-to-clear faults, ordered low to high as bits 0,1,2,5,6,7
  localparam int CSR_RC_COUNT = 6;

  // Consecutive failed restarts before the short latch sets
  localparam int CSR_SHORT_RETRY_LIMIT = 7;
  localparam int CSR_RETRY_WIDTH = 3;

  // Live state from the converter control
  typedef struct packed {
    logic input_present_flag;
    logic optimizer_complete_flag;
    logic supplement_mode_flag;
    logic input_voltage_limit_loop;
    logic bus_output_regulating;
    logic input_current_limit_loop;
    logic fast_charge_flag;
    logic precharge_flag;
    logic bus_supply_flag;
  } csr_state_type;

  // Fault conditions, level while present
  typedef struct packed {
    logic input_overvoltage_fault;
    logic battery_overcurrent_fault;
    logic input_overcurrent_fault;
    logic system_overvoltage;
    logic latchoff_fault;
    logic bus_supply_overvoltage_fault;
    logic bus_supply_undervoltage_fault;
  } csr_fault_type;

  // Host access strobes, one cycle each
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } csr_host_type;

endpackage

// >>> src/csr_rc_flag.sv
/*
  One sticky fault flag cleared by a host read.
  Assumes fault_in is a level held while the fault is present.
*/
module csr_rc_flag
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Fault and clearing
  input wire logic fault_in,
  input wire logic read_clear_in,
  // Flag
  output logic flag_out
);

  logic flag_reg;

  // Present fault keeps the flag set, even against a read
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      flag_reg <= 1'b0;
    end
    else if (fault_in)
    begin
      flag_reg <= 1'b1;
    end
    else if (read_clear_in)
    begin
      flag_reg <= 1'b0;
    end
  end

  assign flag_out = flag_reg;

endmodule // csr_rc_flag

// >>> src/csr_status.sv
/*
  Charger state and fault status register, SMBus command 0x20.
  Holds live state bits, read-to-clear fault latches, the system
  over-voltage latch with converter disable, and the system short latch
  with its hiccup retry counter.
  Assumes an SMBus slave outside that presents one-cycle read and write
  strobes, and converter control that supplies state and fault levels.
*/
// Behaviour
// RULE1 - Bit 15 shows whether an input source is present.
// RULE2 - Bit 14 shows the input current optimizer finished successfully.
// RULE3 - Bit 13 shows minimum-voltage active protection mode; read-only.
// RULE4 - Bit 12 shows input voltage loop, or bus output regulation in supply mode.
// RULE5 - Bit 11 shows the input current limit loop is regulating.
// RULE6 - Bit 10 shows the fast charge phase.
// RULE7 - Bit 9 shows the pre-charge phase.
// RULE8 - Bit 8 shows the battery supplies the USB bus.
// RULE9 - Input over-voltage latches bit 7; read clears it once gone.
// RULE10 - Battery over-current latches bit 6; read clears it once gone.
// RULE11 - Input over-current latches bit 5; read clears it once gone.
// RULE12 - System over-voltage sets bit 4 and holds the converter disabled.
// RULE13 - Writing 0 to bit 4 or adapter removal clears the latch.
// RULE14 - With hiccup enabled, seven consecutive failed restarts latch bit 3.
// RULE15 - Only writing 0 clears bit 3; reads leave it.
// RULE16 - Forced latch-off fault latches bit 2; read clears it once gone.
// RULE17 - Bus supply over-voltage latches bit 1; read clears it once gone.
// RULE18 - Bus supply under-voltage latches bit 0; read clears it once gone.
// RULE19 - Register sits at command 0x20 and resets to zero.
// RULE20 - Writes to read-only and read-clear bits are ignored; present faults survive reads.

module csr_status
  import csr_pkg::*;
#(
  parameter int RETRY_LIMIT = csr_pkg::CSR_SHORT_RETRY_LIMIT
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Host access
  input wire csr_pkg::csr_host_type host_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  // Converter state and faults
  input wire csr_pkg::csr_state_type state_in,
  input wire csr_pkg::csr_fault_type fault_in,
  input wire logic adapter_removed_in,
  // System short hiccup
  input wire logic short_hiccup_disable_in,
  input wire logic restart_fail_in,
  input wire logic restart_ok_in,
  // Converter control
  output logic converter_disable_out
);

  import csr_pkg::*;

  function automatic logic hit(input csr_host_type h);
    hit = (h.cmd == CSR_CMD_STATUS);
  endfunction

  logic read_hit;
  logic write_hit;
  logic [15:0] live_word;
  logic [CSR_RC_COUNT-1:0] rc_fault;
  logic [CSR_RC_COUNT-1:0] rc_flag;
  logic [7:0] state_reg;
  logic sys_ov_reg;
  logic short_reg;
  logic [CSR_RETRY_WIDTH:0] retry_reg;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic conv_dis_reg;

  assign read_hit = host_in.rd && hit(host_in); // RULE19
  assign write_hit = host_in.wr && hit(host_in); // RULE19

  // Live state sampled once so a read sees a coherent word
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_reg <= CSR_STATUS_RESET[15:8]; // RULE19
    end
    else
    begin
      state_reg[7] <= state_in.input_present_flag; // RULE1
      state_reg[6] <= state_in.optimizer_complete_flag; // RULE2
      state_reg[5] <= state_in.supplement_mode_flag; // RULE3
      state_reg[4] <= state_in.bus_supply_flag ? state_in.bus_output_regulating
        : state_in.input_voltage_limit_loop; // RULE4
      state_reg[3] <= state_in.input_current_limit_loop; // RULE5
      state_reg[2] <= state_in.fast_charge_flag; // RULE6
      state_reg[1] <= state_in.precharge_flag; // RULE7
      state_reg[0] <= state_in.bus_supply_flag; // RULE8
    end
  end

  assign rc_fault = {fault_in.input_overvoltage_fault, // RULE9
                     fault_in.battery_overcurrent_fault, // RULE10
                     fault_in.input_overcurrent_fault, // RULE11
                     fault_in.latchoff_fault, // RULE16
                     fault_in.bus_supply_overvoltage_fault, // RULE17
                     fault_in.bus_supply_undervoltage_fault}; // RULE18

  // Flags clear on the read that returns them once the fault is gone, so the host then sees the 1 once
  genvar gi;
  generate
    for (gi = 0; gi < CSR_RC_COUNT; gi++)
    begin : g_rc
      csr_rc_flag u_flag
      (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .fault_in(rc_fault[gi]),
        .read_clear_in(read_hit), // RULE20
        .flag_out(rc_flag[gi])
      );
    end
  endgenerate

  // Set wins over a clearing write while the over-voltage persists
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sys_ov_reg <= CSR_STATUS_RESET[CSR_BIT_SYS_OV];
    end
    else if (fault_in.system_overvoltage)
    begin
      sys_ov_reg <= 1'b1; // RULE12
    end
    else if (adapter_removed_in || (write_hit && !host_in.wdata[CSR_BIT_SYS_OV]))
    begin
      sys_ov_reg <= 1'b0; // RULE13
    end
  end

  // Converter held off for as long as the latch stands
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      conv_dis_reg <= 1'b0;
    end
    else
    begin
      conv_dis_reg <= fault_in.system_overvoltage || sys_ov_reg; // RULE12
    end
  end

  // Counts consecutive failed restarts; a good restart breaks the run
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      retry_reg <= '0;
    end
    else if (short_hiccup_disable_in || restart_ok_in || short_reg)
    begin
      retry_reg <= '0;
    end
    else if (restart_fail_in)
    begin
      retry_reg <= retry_reg + 1'b1; // RULE14
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      short_reg <= CSR_STATUS_RESET[CSR_BIT_SYSTEM_SHORT_FAULT];
    end
    else if (!short_hiccup_disable_in && restart_fail_in &&
             (retry_reg == (CSR_RETRY_WIDTH+1)'(RETRY_LIMIT - 1)))
    begin
      short_reg <= 1'b1; // RULE14
    end
    else if (write_hit && !host_in.wdata[CSR_BIT_SYSTEM_SHORT_FAULT])
    begin
      short_reg <= 1'b0; // RULE15
    end
  end

  always_comb
  begin
    live_word = {state_reg, rc_flag[5:3], sys_ov_reg, short_reg, rc_flag[2:0]};
  end

  // Read data registered; one cycle after the strobe
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rdata_reg <= CSR_STATUS_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= read_hit;
      if (read_hit)
      begin
        rdata_reg <= live_word;
      end
    end
  end

  assign rdata_out = rdata_reg;
  assign rvalid_out = rvalid_reg;
  assign converter_disable_out = conv_dis_reg;

endmodule // csr_status

// >>> testbench/csr_host_model.sv
/* Host model: decoded SMBus read and write strobes.
   Assumes each call starts at a rising clock edge. */
module csr_host_model
  import csr_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Strobes
  output csr_pkg::csr_host_type host_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_out = '0;
  // One-cycle strobe, as the slave front end gives it
  task automatic access(input logic rd, input logic [7:0] cmd, input logic [15:0] wd);
    host_out <= '{rd, !rd, cmd, wd};
    @(posedge clk_sys_in);
    host_out <= '0;
    #1;
  endtask
endmodule // csr_host_model

// >>> testbench/csr_status_props.sv
/* Checker on the status register ports.
   Assumes one clock and a synchronous active-high reset. */
module csr_status_props
  import csr_pkg::*;
#(
  parameter int RETRY_LIMIT = 7
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Watched ports
  input wire csr_pkg::csr_host_type host_in,
  input wire logic [15:0] rdata_out,
  input wire logic rvalid_out,
  input wire csr_pkg::csr_state_type state_in,
  input wire csr_pkg::csr_fault_type fault_in,
  input wire logic converter_disable_out
);
  logic hit;
  logic vsrc;
  logic [6:0] st_now;
  logic [5:0] rc_now;
  assign hit = host_in.rd && host_in.cmd == CSR_CMD_STATUS;
  assign vsrc = state_in[0] ? state_in[4] : state_in[5];
  assign st_now = {state_in[8:6], state_in[3:0]};
  assign rc_now = {fault_in[6:4], fault_in[2:0]};
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  a_read_answer:
    assert property (hit |=> rvalid_out) else $error("no answer");
  a_no_stray:
    assert property (!hit |=> !rvalid_out) else $error("stray rvalid");
  a_rdata_hold:
    assert property (!rvalid_out |-> $stable(rdata_out)) else $error("rdata moved");
  a_state_bits:
    assert property (rvalid_out |-> {rdata_out[15:13], rdata_out[11:8]} == $past(st_now, 2)) else $error("state");
  a_volt_bit:
    assert property (rvalid_out |-> rdata_out[12] == $past(vsrc, 2)) else $error("volt bit");
  a_fault_latched:
    assert property (rvalid_out |-> ({rdata_out[7:5], rdata_out[2:0]} | $past(rc_now, 2)) ==
      {rdata_out[7:5], rdata_out[2:0]}) else $error("fault lost");
  a_read_clears:
    assert property ((hit && rc_now == 6'h00) ##1 rc_now == 6'h00 ##1 (hit && rc_now == 6'h00) |=>
      {rdata_out[7:5], rdata_out[2:0]} == 6'h00) else $error("not cleared");
  a_ovp_off:
    assert property (fault_in[3] |-> ##[1:2] converter_disable_out) else $error("converter on");
  a_ovp_hold:
    assert property (rvalid_out && rdata_out[4] |-> converter_disable_out) else $error("latch without disable");
  c_read: cover property (hit ##1 rvalid_out);
  c_short: cover property (rvalid_out && rdata_out[3]);
  c_reenable: cover property (converter_disable_out ##1 !converter_disable_out);
endmodule // csr_status_props

bind csr_status csr_status_props #(.RETRY_LIMIT(RETRY_LIMIT)) i_csr_status_props (.clk_sys_in(clk_sys_in),
  .rst_in(rst_in), .host_in(host_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .state_in(state_in),
  .fault_in(fault_in), .converter_disable_out(converter_disable_out));

// >>> testbench/csr_status_bench.sv
/* Bench for the status register: table-driven reads and writes.
   Assumes the host model and checker beside it. */
module csr_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import csr_pkg::*;
  logic clk_sys_in;
  logic rst_in;
  csr_host_type host;
  logic [15:0] rdata;
  logic rvalid;
  csr_state_type st;
  csr_fault_type ft;
  logic arm;
  logic hdis;
  logic rf;
  logic rok;
  logic cdis;
  int err_count = 0;
  int compares = 0;
  // Last entry: input voltage loop active while supplying the bus must not show
  logic [8:0] st_tab [11] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001, 9'h011,
    9'h021};
  logic [15:0] sw_tab [11] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0000, 16'h0800, 16'h0400,
    16'h0200, 16'h0100, 16'h1100, 16'h0100};
  logic [6:0] ft_tab [6] = '{7'h40, 7'h20, 7'h10, 7'h04, 7'h02, 7'h01};
  logic [15:0] fw_tab [6] = '{16'h0080, 16'h0040, 16'h0020, 16'h0004, 16'h0002, 16'h0001};
  csr_status i_csr_status (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_in(host), .rdata_out(rdata),
    .rvalid_out(rvalid), .state_in(st), .fault_in(ft), .adapter_removed_in(arm), .short_hiccup_disable_in(hdis),
    .restart_fail_in(rf), .restart_ok_in(rok), .converter_disable_out(cdis));
  csr_host_model i_csr_host_model (.clk_sys_in(clk_sys_in), .host_out(host));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [15:0] exp, input logic v, input logic [7:0] cmd = CSR_CMD_STATUS);
    @(posedge clk_sys_in);
    i_csr_host_model.access(1'b1, cmd, 16'h0000);
    chk("rvalid", 16'(v), 16'(rvalid));
    if (v)
      chk("rdata", exp, rdata);
  endtask
  task automatic wr(input logic [15:0] wd);
    @(posedge clk_sys_in);
    i_csr_host_model.access(1'b0, CSR_CMD_STATUS, wd);
  endtask
  task automatic fails(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_in);
      rf <= 1'b1;
      @(posedge clk_sys_in);
      rf <= 1'b0;
    end
  endtask
  task automatic end_of_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    end_of_test();
  end
  initial
  begin
    {rst_in, st, ft, arm, hdis, rf, rok} = {1'b1, 20'h00000};
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_chk(16'h0000, 1'b1);
    rd_chk(16'h0000, 1'b0, 8'h21);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk_sys_in);
      st <= st_tab[i];
      wr(16'hFFFF);
      rd_chk(sw_tab[i], 1'b1);
    end
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys_in);
      st <= '0;
      ft <= ft_tab[i];
      rd_chk(fw_tab[i], 1'b1);
      rd_chk(fw_tab[i], 1'b1);
      @(posedge clk_sys_in);
      ft <= '0;
      wr(16'h0000);
      rd_chk(fw_tab[i], 1'b1);
      rd_chk(16'h0000, 1'b1);
    end
    // Pass 0 clears by write, pass 1 by adapter removal
    for (int j = 0; j < 2; j++)
    begin
      @(posedge clk_sys_in);
      ft <= 7'h08;
      rd_chk(16'h0010, 1'b1);
      @(posedge clk_sys_in);
      ft <= '0;
      wr(16'hFFFF);
      rd_chk(16'h0010, 1'b1);
      chk("cdis", 16'h0001, 16'(cdis));
      if (j == 0)
        wr(16'hFFEF);
      @(posedge clk_sys_in);
      arm <= j[0];
      @(posedge clk_sys_in);
      arm <= 1'b0;
      rd_chk(16'h0000, 1'b1);
      chk("cdis", 16'h0000, 16'(cdis));
    end
    @(posedge clk_sys_in);
    hdis <= 1'b1;
    fails(7);
    rd_chk(16'h0000, 1'b1);
    @(posedge clk_sys_in);
    hdis <= 1'b0;
    fails(6);
    rok <= 1'b1;
    @(posedge clk_sys_in);
    rok <= 1'b0;
    fails(6);
    rd_chk(16'h0000, 1'b1);
    fails(1);
    rd_chk(16'h0008, 1'b1);
    rd_chk(16'h0008, 1'b1);
    wr(16'hFFF7);
    rd_chk(16'h0000, 1'b1);
    // Mid-run reset must drop every latch set by live faults
    @(posedge clk_sys_in);
    ft <= 7'h7F;
    rd_chk(16'h00F7, 1'b1);
    @(posedge clk_sys_in);
    ft <= '0;
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_chk(16'h0000, 1'b1);
    chk("cdis", 16'h0000, 16'(cdis));
    end_of_test();
  end
endmodule // csr_status_bench
